// ### inc/plc_pkg.sv
// Constants and helpers shared by the PHY-link pin control block
package plc_pkg;

   // ******************************
   // Control bus codes
   // ******************************
   // Driven by the PHY
   localparam logic [1:0] CTL_IDLE      = 2'h0;
   localparam logic [1:0] CTL_STATUS    = 2'h1;
   localparam logic [1:0] CTL_RECEIVE   = 2'h2;
   localparam logic [1:0] CTL_GRANT     = 2'h3;
   // Driven by the link after a grant
   localparam logic [1:0] LCTL_IDLE     = 2'h0;
   localparam logic [1:0] LCTL_TRANSMIT = 2'h1;
   localparam logic [1:0] LCTL_HOLD     = 2'h3;

   // ******************************
   // Speed codes and lane masks
   // ******************************
   localparam logic [1:0] SPD_100  = 2'h0;
   localparam logic [1:0] SPD_200  = 2'h1;
   localparam logic [1:0] SPD_400  = 2'h2;
   localparam logic [7:0] MASK_100 = 8'h03;
   localparam logic [7:0] MASK_200 = 8'h0f;
   localparam logic [7:0] MASK_400 = 8'hff;

   // ******************************
   // Reset values
   // ******************************
   localparam logic [1:0] CTL_RESET_LEVEL  = 2'h0;
   localparam logic [7:0] DATA_RESET_LEVEL = 8'h00;

   // ******************************
   // Link request framing
   // ******************************
   localparam logic [3:0] LREQ_BITS = 4'h8;

   // ******************************
   // Clock relations
   // ******************************
   localparam int PHY_CLK_KHZ  = 49152;
   localparam int LINK_DIV     = 2;
   localparam int LINK_CLK_KHZ = PHY_CLK_KHZ / LINK_DIV;
   localparam int CYCLE_HZ     = 8000;
   localparam int LINK_TICKS   = (LINK_CLK_KHZ * 1000) / CYCLE_HZ;
   localparam logic [11:0] CYCLE_LAST = 12'(LINK_TICKS - 1);
   localparam logic [11:0] CYCLE_HALF = 12'(LINK_TICKS / 2);
   localparam int HOST_DIV = 16;
   localparam logic [2:0] HOST_HALF_LAST = 3'(HOST_DIV / 2 - 1);

   // Lanes in use for a given speed; reserved code uses all lanes
   function automatic logic [7:0] plc_lane_mask(input logic [1:0] spd);
      case (spd)
         SPD_100: plc_lane_mask = MASK_100;
         SPD_200: plc_lane_mask = MASK_200;
         default: plc_lane_mask = MASK_400;
      endcase
   endfunction : plc_lane_mask

endpackage : plc_pkg

// ### logic/plc_clk_derive.sv
// Edge detection of the PHY and host clocks and the derived link ticks
`timescale 1ns/1ps
`default_nettype none
module plc_clk_derive
   import plc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Sampled clocks
   input  wire logic phy_clk,
   input  wire logic host_clk,
   // Pulses
   output var  logic phy_rise,
   output var  logic link_tick,
   output var  logic host_tick
);

   typedef struct packed {
      logic       phy_q;
      logic       host_q;
      logic       link_clk;
      logic [2:0] host_cnt;
      logic       phy_rise;
      logic       link_tick;
      logic       host_tick;
   } plc_drv_t;

   plc_drv_t s;
   plc_drv_t next_s;

   always_comb begin
      next_s = s;
      next_s.phy_q     = phy_clk;
      next_s.host_q    = host_clk;
      // Edge detection keeps running in reset: reset sequencing counts PHY edges
      next_s.phy_rise  = phy_clk & ~s.phy_q;
      next_s.link_tick = 1'b0;
      next_s.host_tick = 1'b0;
      if (!rst_n) begin
         next_s.link_clk = 1'b0;
         next_s.host_cnt = 3'h0;
      end else begin
         if (phy_clk && !s.phy_q) begin
            next_s.link_clk  = ~s.link_clk;
            next_s.link_tick = ~s.link_clk;
         end
         // Host clock is only sampled, never used as a clock here
         if (host_clk && !s.host_q) begin
            next_s.host_cnt  = s.host_cnt + 3'h1;
            next_s.host_tick = (s.host_cnt == HOST_HALF_LAST);
         end
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign phy_rise  = s.phy_rise;
   assign link_tick = s.link_tick;
   assign host_tick = s.host_tick;

   AST_LINK_HALF_RATE: assert property (@(posedge clk) disable iff (!rst_n)
      link_tick |-> phy_rise ##1 !link_tick [*1] ##0 (!phy_rise || !link_tick))
      else $error("link tick not at half the PHY rate");

endmodule : plc_clk_derive
`default_nettype wire

// ### logic/plc_cycle_timer.sv
// Isochronous cycle clock generation from the link clock or an external input
`timescale 1ns/1ps
`default_nettype none
module plc_cycle_timer
   import plc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Timing sources
   input  wire logic link_tick,
   input  wire logic ext_sel,
   input  wire logic cyc_in,
   input  wire logic cs_rx,
   // Cycle clock
   output var  logic cyc_out,
   output var  logic cyc_start
);

   typedef struct packed {
      logic [11:0] cnt;
      logic        in_q;
      logic        out;
      logic        start;
   } plc_cyc_t;

   plc_cyc_t s;
   plc_cyc_t next_s;

   always_comb begin
      next_s = s;
      next_s.in_q  = cyc_in;
      next_s.start = 1'b0;
      if (!rst_n) begin
         next_s.cnt = 12'h000;
         next_s.out = 1'b0;
         next_s.in_q = 1'b1;
      end else begin
         if (link_tick) begin
            next_s.cnt = (s.cnt == CYCLE_LAST) ? 12'h000 : s.cnt + 12'h001;
         end
         if (ext_sel) begin
            // External input only counts on the cycle-master node
            if (cyc_in && !s.in_q) begin
               next_s.cnt   = 12'h000;
               next_s.start = 1'b1;
            end
         end else if (cs_rx) begin
            // A received cycle start realigns our local timer
            next_s.cnt   = 12'h000;
            next_s.start = 1'b1;
         end else if (link_tick && s.cnt == CYCLE_LAST) begin
            next_s.start = 1'b1;
         end
         next_s.out = (next_s.cnt < CYCLE_HALF);
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign cyc_out   = s.out;
   assign cyc_start = s.start;

   AST_EXT_EDGE_STARTS: assert property (@(posedge clk) disable iff (!rst_n)
      ext_sel && cyc_in && !s.in_q |=> cyc_start && cyc_out)
      else $error("external cycle edge did not start a cycle");

endmodule : plc_cycle_timer
`default_nettype wire

// ### logic/plc_phy_link.sv
// PHY-link pin control: control/data pins, link request, power indicator, cycle pins
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Reset drives control/data low one PHY cycle
// - Two-bit control bus carries four operations
// - Lanes used scale with 100/200/400 speed
// - Link request low at first reset edge
// - Link request carries bus and access requests
// - Power indicator toggles at host clock/16
// - Power indicator held low during reset
// - PHY clock halved into internal link clock
// - Host clock domain is asynchronous, handled carefully
// - External cycle input used only when selected
// - Cycle clock output from timer and starts
// - Cycle-done pin follows its flag
// - Cycle-started pin follows its flag
// - Reset active low, acts on all logic except the PHY/host clock edge detectors
module plc_phy_link
   import plc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Sampled clocks
   input  wire logic       phy_clk,
   input  wire logic       host_clk,
   // PHY control pins
   input  wire logic [1:0] ctl_in,
   output var  logic [1:0] ctl_out,
   output var  logic       ctl_oe,
   // PHY data pins
   input  wire logic [7:0] phy_d_in,
   output var  logic [7:0] phy_d_out,
   output var  logic       phy_d_oe,
   // Link request pin and its request port
   output var  logic       lreq,
   input  wire logic [7:0] req_word,
   input  wire logic       req_valid,
   output var  logic       req_busy,
   // Packet data toward and from the PHY
   input  wire logic [1:0] speed,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_last,
   output var  logic       tx_taken,
   output var  logic [7:0] rx_data,
   output var  logic       rx_valid,
   // Power indicator
   input  wire logic       powered_en,
   output var  logic       link_powered_indicator,
   // Cycle clock
   input  wire logic       cycle_src_ext,
   input  wire logic       cycle_clock_input,
   input  wire logic       cycle_start_rx,
   output var  logic       cycle_clock_output,
   // Cycle status
   input  wire logic       cycle_done_evt,
   input  wire logic       cycle_done_clr,
   input  wire logic       cycle_started_clr,
   output var  logic       cycle_done_pin,
   output var  logic       cycle_started_pin
);

   // ******************************
   // State
   // ******************************
   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_TX, ST_END} plc_st_t;

   typedef struct packed {
      plc_st_t    st;
      logic       in_reset;
      logic       init_seen;
      logic [1:0] ctl_out;
      logic       ctl_oe;
      logic [7:0] d_out;
      logic       d_oe;
      logic       lreq;
      logic [7:0] lreq_sh;
      logic [3:0] lreq_cnt;
      logic       req_busy;
      logic       tx_taken;
      logic [7:0] rx_data;
      logic       rx_valid;
      logic       powered;
      logic       cycle_done_flag;
      logic       cycle_started_flag;
   } plc_state_t;

   plc_state_t s;
   plc_state_t next_s;

   logic phy_rise;
   logic link_tick;
   logic host_tick;
   logic cyc_start;

   // ******************************
   // Clock derivation and cycle timer
   // ******************************
   plc_clk_derive u_clk (
      .clk       (clk),
      .rst_n     (rst_n),
      .phy_clk   (phy_clk),
      .host_clk  (host_clk),
      .phy_rise  (phy_rise),
      .link_tick (link_tick),
      .host_tick (host_tick)
   );

   plc_cycle_timer u_cyc (
      .clk       (clk),
      .rst_n     (rst_n),
      .link_tick (link_tick),
      .ext_sel   (cycle_src_ext),
      .cyc_in    (cycle_clock_input),
      .cs_rx     (cycle_start_rx),
      .cyc_out   (cycle_clock_output),
      .cyc_start (cyc_start)
   );

   // One transmit step after a grant: send a byte, or hold while none is ready
   function automatic plc_state_t tx_step(input plc_state_t cur, input logic vld, input logic last,
                                          input logic [7:0] dat, input logic [1:0] spd);
      plc_state_t r;
      r = cur;
      r.ctl_oe = 1'b1;
      r.d_oe   = 1'b1;
      if (vld) begin
         r.ctl_out  = LCTL_TRANSMIT;
         r.d_out    = dat & plc_lane_mask(spd);
         r.tx_taken = 1'b1;
         r.st       = last ? ST_END : ST_TX;
      end else begin
         r.ctl_out = LCTL_HOLD;
         r.d_out   = DATA_RESET_LEVEL;
         r.st      = ST_TX;
      end
      return r;
   endfunction : tx_step

   // ******************************
   // Next state
   // ******************************
   always_comb begin
      next_s = s;
      next_s.tx_taken = 1'b0;
      next_s.rx_valid = 1'b0;
      if (!rst_n) begin
         // Every register except init_seen, ctl_oe and d_oe is forced here, whatever the PHY clock does
         next_s.st                 = ST_INIT;
         next_s.in_reset           = 1'b1;
         next_s.ctl_out            = CTL_RESET_LEVEL;
         next_s.d_out              = DATA_RESET_LEVEL;
         next_s.lreq               = 1'b0;
         next_s.lreq_sh            = 8'h00;
         next_s.lreq_cnt           = 4'h0;
         next_s.req_busy           = 1'b0;
         next_s.rx_data            = 8'h00;
         next_s.powered            = 1'b0;
         next_s.cycle_done_flag    = 1'b0;
         next_s.cycle_started_flag = 1'b0;
         if (s.in_reset) begin
            // Drive low for one PHY cycle, then leave the lines to the bus holders
            next_s.init_seen = s.init_seen | phy_rise;
            next_s.ctl_oe    = s.ctl_oe & ~(s.init_seen & phy_rise);
            next_s.d_oe      = s.d_oe & ~(s.init_seen & phy_rise);
         end else begin
            // Entry into reset; an unknown state at power-up lands here too
            next_s.init_seen = 1'b0;
            next_s.ctl_oe    = 1'b1;
            next_s.d_oe      = 1'b1;
         end
      end else begin
         next_s.in_reset = 1'b0;

         // Link request shifter, MSB first, one bit per PHY clock
         if (!s.req_busy && req_valid) begin
            next_s.lreq_sh  = req_word;
            next_s.lreq_cnt = LREQ_BITS;
            next_s.req_busy = 1'b1;
         end else if (s.req_busy && phy_rise) begin
            if (s.lreq_cnt != 4'h0) begin
               next_s.lreq     = s.lreq_sh[7];
               next_s.lreq_sh  = {s.lreq_sh[6:0], 1'b0};
               next_s.lreq_cnt = s.lreq_cnt - 4'h1;
            end else begin
               next_s.lreq     = 1'b0;
               next_s.req_busy = 1'b0;
            end
         end

         // Control and data bus
         if (phy_rise) begin
            case (s.st)
               ST_INIT: begin
                  // Finish the reset drive if reset was shorter than a PHY cycle
                  next_s.ctl_oe = 1'b0;
                  next_s.d_oe   = 1'b0;
                  next_s.st     = ST_IDLE;
               end
               ST_IDLE: begin
                  case (ctl_in)
                     CTL_RECEIVE: begin
                        next_s.rx_data  = phy_d_in & plc_lane_mask(speed);
                        next_s.rx_valid = 1'b1;
                     end
                     CTL_GRANT: next_s = tx_step(next_s, tx_valid, tx_last, tx_data, speed);
                     default: next_s.st = ST_IDLE;
                  endcase
               end
               ST_TX: next_s = tx_step(next_s, tx_valid, tx_last, tx_data, speed);
               ST_END: begin
                  if (s.ctl_out == LCTL_IDLE) begin
                     // Idle driven for one cycle; hand the bus back
                     next_s.ctl_oe = 1'b0;
                     next_s.d_oe   = 1'b0;
                     next_s.st     = ST_IDLE;
                  end else begin
                     next_s.ctl_out = LCTL_IDLE;
                     next_s.d_out   = DATA_RESET_LEVEL;
                  end
               end
               default: next_s.st = ST_IDLE;
            endcase
         end

         // Power indicator
         if (!powered_en) begin
            next_s.powered = 1'b0;
         end else if (host_tick) begin
            next_s.powered = ~s.powered;
         end

         // Status flags: a new event wins over a clear in the same cycle
         next_s.cycle_done_flag    = cycle_done_evt | (s.cycle_done_flag & ~cycle_done_clr);
         next_s.cycle_started_flag = cyc_start | (s.cycle_started_flag & ~cycle_started_clr);
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   // ******************************
   // Outputs
   // ******************************
   assign ctl_out                = s.ctl_out;
   assign ctl_oe                 = s.ctl_oe;
   assign phy_d_out              = s.d_out;
   assign phy_d_oe               = s.d_oe;
   assign lreq                   = s.lreq;
   assign req_busy               = s.req_busy;
   assign tx_taken               = s.tx_taken;
   assign rx_data                = s.rx_data;
   assign rx_valid               = s.rx_valid;
   assign link_powered_indicator = s.powered;
   assign cycle_done_pin         = s.cycle_done_flag;
   assign cycle_started_pin      = s.cycle_started_flag;

   // ******************************
   // Checks
   // ******************************
   AST_RESET_LINES_LOW: assert property (@(posedge clk)
      !rst_n ##1 !rst_n |-> ctl_out == CTL_RESET_LEVEL && phy_d_out == DATA_RESET_LEVEL)
      else $error("PHY lines not low in reset");

   AST_RESET_RELEASE: assert property (@(posedge clk)
      !rst_n && s.in_reset && s.init_seen && phy_rise |=> !ctl_oe && !phy_d_oe)
      else $error("PHY lines not released after one PHY cycle");

   AST_RESET_LREQ_LOW: assert property (@(posedge clk)
      !rst_n && phy_rise |=> !lreq)
      else $error("link request not low in reset");

   AST_RESET_POWER_LOW: assert property (@(posedge clk)
      !rst_n |=> !link_powered_indicator)
      else $error("power indicator not low in reset");

   AST_LANE_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      phy_d_oe && s.st != ST_INIT && $past(speed) == SPD_100 && $stable(speed) |-> phy_d_out[7:2] == 6'h00)
      else $error("unused lanes driven at lowest speed");

   AST_RX_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
      s.st == ST_IDLE && phy_rise && ctl_in == CTL_RECEIVE
      |=> rx_valid && rx_data == ($past(phy_d_in) & plc_lane_mask($past(speed))))
      else $error("received data not captured");

   AST_GRANT_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
      s.st == ST_IDLE && phy_rise && ctl_in == CTL_GRANT |=> ctl_oe && phy_d_oe && ctl_out != LCTL_IDLE)
      else $error("link did not take the bus on grant");

   AST_LREQ_ACCEPT: assert property (@(posedge clk) disable iff (!rst_n)
      req_valid && !req_busy |=> req_busy && !lreq)
      else $error("link request not accepted");

   AST_POWER_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
      powered_en && host_tick |=> link_powered_indicator != $past(link_powered_indicator))
      else $error("power indicator did not toggle");

   AST_DONE_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
      cycle_done_evt |=> cycle_done_pin ##0 (cycle_done_clr || cycle_done_evt || cycle_done_pin) [*1])
      else $error("cycle-done event lost");

   AST_STARTED_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
      cyc_start |=> cycle_started_pin)
      else $error("cycle-started pin did not follow the event");

endmodule : plc_phy_link
`default_nettype wire

// ### testbench/plc_phy_model.sv
// PHY partner model: clock source, pin drive and bus holders
`timescale 1ns/1ps
`default_nettype none
module plc_phy_model
   import plc_pkg::*;
(
   // Clock toward the link
   output var logic       phy_clk,
   // Commands from the bench
   input  wire logic       cmd_en,
   input  wire logic [1:0] cmd_ctl,
   input  wire logic [7:0] cmd_d,
   // Link side of the pins
   input  wire logic [1:0] ctl_out,
   input  wire logic       ctl_oe,
   input  wire logic [7:0] phy_d_out,
   input  wire logic       phy_d_oe,
   // Resolved pin levels
   output var logic [1:0] ctl_in,
   output var logic [7:0] phy_d_in
);
   logic       drv = 1'b0;
   logic [1:0] drv_ctl = 2'h0;
   logic [7:0] drv_d = 8'h00;
   // Free running 49.152 MHz source
   initial phy_clk = 1'b0;
   always #10.1725 phy_clk = ~phy_clk;
   // The PHY launches its drive on its own clock
   always @(posedge phy_clk) begin
      drv     <= cmd_en;
      drv_ctl <= cmd_ctl;
      drv_d   <= cmd_d;
   end
   // Holders keep the last level; they start opposite to the reset level
   // No barrier on this board, so isolation never applies
   initial ctl_in = 2'h3;
   initial phy_d_in = 8'hff;
   always @* begin
      if (ctl_oe === 1'b1) ctl_in = ctl_out;
      else if (drv) ctl_in = drv_ctl;
   end
   always @* begin
      if (phy_d_oe === 1'b1) phy_d_in = phy_d_out;
      else if (drv) phy_d_in = drv_d;
   end
endmodule : plc_phy_model
`default_nettype wire

// ### testbench/plc_phy_link_tb.sv
// Self-checking bench for the PHY-link pin control block
`timescale 1ns/1ps
`default_nettype none
module plc_phy_link_tb;
   import plc_pkg::*;
   logic       clk, rst_n, host_clk, phy_clk, cmd_en;
   logic [1:0] ctl_in, ctl_out, speed, cmd_ctl;
   logic [7:0] phy_d_in, phy_d_out, req_word, tx_data, rx_data, cmd_d, got;
   logic       ctl_oe, phy_d_oe, lreq, req_valid, req_busy, tx_valid, tx_last, tx_taken, rx_valid;
   logic       powered_en, link_powered_indicator, cycle_src_ext, cycle_clock_input, cycle_start_rx;
   logic       cycle_clock_output, cycle_done_evt, cycle_done_clr, cycle_started_clr;
   logic       cycle_done_pin, cycle_started_pin;
   int         err_count = 0;
   int         compares = 0;
   int         nbits = 0;
   int         host_cnt = 0;

   initial clk = 1'b0;
   always #4 clk = ~clk;
   // Host clock kept off the sampling grid on purpose
   initial host_clk = 1'b0;
   always #21 host_clk = ~host_clk;
   always @(posedge host_clk) host_cnt++;

   plc_phy_link dut (.clk(clk), .rst_n(rst_n), .phy_clk(phy_clk), .host_clk(host_clk),
      .ctl_in(ctl_in), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .phy_d_in(phy_d_in), .phy_d_out(phy_d_out),
      .phy_d_oe(phy_d_oe), .lreq(lreq), .req_word(req_word), .req_valid(req_valid), .req_busy(req_busy),
      .speed(speed), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_taken(tx_taken),
      .rx_data(rx_data), .rx_valid(rx_valid), .powered_en(powered_en),
      .link_powered_indicator(link_powered_indicator), .cycle_src_ext(cycle_src_ext),
      .cycle_clock_input(cycle_clock_input), .cycle_start_rx(cycle_start_rx),
      .cycle_clock_output(cycle_clock_output), .cycle_done_evt(cycle_done_evt),
      .cycle_done_clr(cycle_done_clr), .cycle_started_clr(cycle_started_clr),
      .cycle_done_pin(cycle_done_pin), .cycle_started_pin(cycle_started_pin));

   plc_phy_model phy (.phy_clk(phy_clk), .cmd_en(cmd_en), .cmd_ctl(cmd_ctl), .cmd_d(cmd_d),
      .ctl_out(ctl_out), .ctl_oe(ctl_oe), .phy_d_out(phy_d_out), .phy_d_oe(phy_d_oe),
      .ctl_in(ctl_in), .phy_d_in(phy_d_in));

   // ******************************
   // Helpers
   // ******************************
   task automatic give_verdict();
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic tmo(input int k, input string m);
      if (k <= 0) begin
         err_count++;
         $display("wrong value at %0t: timeout %s", $time, m);
         give_verdict();
      end
   endtask : tmo

   task automatic wait_lv(ref logic s, input logic v, input int n, input string m);
      while (s !== v && n > 0) begin
         @(negedge clk);
         n--;
      end
      tmo(n, m);
   endtask : wait_lv

   // A run of equal levels spans about 2.54 clocks per bit
   task automatic add_run(input logic v, input int len);
      repeat ((len * 8000 + 10172) / 20345) begin
         got = {got[6:0], v};
         nbits++;
      end
   endtask : add_run

   task automatic pulse_in();
      cycle_clock_input = 1'b0;
      repeat (5) @(negedge clk);
      cycle_clock_input = 1'b1;
   endtask : pulse_in

   // ******************************
   // Scenarios
   // ******************************
   task automatic reset_check();
      repeat (2) @(negedge clk);
      chk({ctl_oe, phy_d_oe, ctl_out, phy_d_out}, 32'hc00, "reset drive");
      chk({lreq, link_powered_indicator}, 0, "reset outputs");
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      wait_lv(ctl_oe, 1'b0, 20, "ctl release");
      wait_lv(phy_d_oe, 1'b0, 20, "data release");
      chk({ctl_in, phy_d_in}, 0, "held low");
   endtask : reset_check

   task automatic link_request();
      int k;
      int len;
      logic cur;
      bit on;
      k = 400;
      len = 0;
      cur = 1'b1;
      on = 0;
      req_word = 8'hb2;
      req_valid = 1'b1;
      wait_lv(req_busy, 1'b1, 4, "busy");
      req_valid = 1'b0;
      while (req_busy === 1'b1 && k > 0) begin
         // A request while busy must be ignored
         if (k == 390) req_word = 8'hff;
         req_valid = (k <= 390 && k > 388);
         on = on | (lreq === 1'b1);
         if (on && lreq === cur) len++;
         else if (on) begin
            add_run(cur, len);
            cur = lreq;
            len = 1;
         end
         @(negedge clk);
         k--;
      end
      tmo(k, "request");
      add_run(cur, len);
      chk({nbits[7:0], got, 7'h00, lreq}, 32'h0008b200, "request bits");
   endtask : link_request

   task automatic receive();
      speed = SPD_400;
      cmd_d = 8'hc3;
      cmd_ctl = CTL_RECEIVE;
      cmd_en = 1'b1;
      wait_lv(rx_valid, 1'b1, 20, "rx");
      chk(rx_data, 8'hc3, "rx byte");
      cmd_ctl = CTL_IDLE;
      repeat (8) @(negedge clk);
      cmd_en = 1'b0;
   endtask : receive

   task automatic transmit(input logic [1:0] s, input logic [7:0] mask);
      speed = s;
      tx_data = 8'h5a;
      tx_valid = 1'b1;
      tx_last = 1'b0;
      cmd_ctl = CTL_GRANT;
      cmd_en = 1'b1;
      @(posedge phy_clk);
      #1 cmd_en = 1'b0;
      wait_lv(tx_taken, 1'b1, 40, "first byte");
      chk({ctl_oe, ctl_out, phy_d_out}, {1'b1, LCTL_TRANSMIT, 8'h5a & mask}, "byte one");
      @(negedge clk);
      tx_data = 8'ha5;
      tx_last = 1'b1;
      wait_lv(tx_taken, 1'b1, 40, "last byte");
      chk(phy_d_out, 8'ha5 & mask, "byte two");
      @(negedge clk);
      tx_valid = 1'b0;
      tx_last = 1'b0;
      wait_lv(ctl_oe, 1'b0, 40, "tx release");
      chk(ctl_in, LCTL_IDLE, "tx ends idle");
   endtask : transmit

   task automatic flags_check();
      cycle_done_evt = 1'b1;
      @(negedge clk);
      cycle_done_evt = 1'b0;
      repeat (5) @(negedge clk);
      chk(cycle_done_pin, 1, "done set");
      cycle_done_evt = 1'b1;
      cycle_done_clr = 1'b1;
      @(negedge clk);
      chk(cycle_done_pin, 1, "set wins");
      cycle_done_evt = 1'b0;
      @(negedge clk);
      cycle_done_clr = 1'b0;
      chk(cycle_done_pin, 0, "done clear");
      cycle_start_rx = 1'b1;
      @(negedge clk);
      cycle_start_rx = 1'b0;
      repeat (3) @(negedge clk);
      chk(cycle_started_pin, 1, "started set");
      cycle_started_clr = 1'b1;
      @(negedge clk);
      cycle_started_clr = 1'b0;
      chk(cycle_started_pin, 0, "started clear");
   endtask : flags_check

   task automatic power_check();
      int h;
      int k;
      logic v;
      wait_lv(link_powered_indicator, 1'b0, 400, "powered");
      wait_lv(link_powered_indicator, 1'b1, 400, "powered");
      h = host_cnt;
      wait_lv(link_powered_indicator, 1'b0, 400, "powered");
      chk(host_cnt - h, 8, "powered half period");
      powered_en = 1'b0;
      repeat (20) @(negedge clk);
      v = link_powered_indicator;
      k = 0;
      repeat (400) begin
         @(negedge clk);
         if (link_powered_indicator !== v) k++;
      end
      chk(k, 0, "powered idle");
      powered_en = 1'b1;
   endtask : power_check

   task automatic cycle_check();
      int len;
      len = 0;
      cycle_start_rx = 1'b1;
      @(negedge clk);
      cycle_start_rx = 1'b0;
      wait_lv(cycle_clock_output, 1'b1, 10, "cycle high");
      while (cycle_clock_output === 1'b1 && len < 9000) begin
         @(negedge clk);
         len++;
      end
      // Half cycle is 1536 link ticks, 7812.5 clocks
      chk(len >= 7808 && len <= 7816, 1, "cycle half");
      repeat (300) @(negedge clk);
      pulse_in();
      repeat (20) @(negedge clk);
      chk(cycle_clock_output, 0, "input unselected");
      cycle_src_ext = 1'b1;
      pulse_in();
      wait_lv(cycle_clock_output, 1'b1, 10, "input selected");
   endtask : cycle_check

   task automatic mid_reset();
      cycle_done_evt = 1'b1;
      @(negedge clk);
      cycle_done_evt = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk({cycle_done_pin, cycle_clock_output, lreq, link_powered_indicator}, 0, "mid reset");
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
   endtask : mid_reset

   initial begin
      rst_n = 1'b0;
      {req_word, req_valid, speed, tx_data, tx_valid, tx_last, cmd_en, cmd_ctl, cmd_d} = '0;
      {cycle_src_ext, cycle_start_rx, cycle_done_evt, cycle_done_clr, cycle_started_clr} = '0;
      powered_en = 1'b1;
      cycle_clock_input = 1'b1;
      got = 8'h00;
      reset_check();
      link_request();
      receive();
      transmit(SPD_100, MASK_100);
      transmit(SPD_200, MASK_200);
      transmit(SPD_400, MASK_400);
      transmit(2'h3, MASK_400);
      flags_check();
      power_check();
      cycle_check();
      mid_reset();
      give_verdict();
   end
endmodule : plc_phy_link_tb
`default_nettype wire
